/* src/gmhp_pkg.sv */
// constants, states and carriers shared by the gauge mode controller and its host port
`default_nettype none
package gmhp_pkg;
	// host port addressing
	localparam logic [6:0] DEV_ADDR = 7'h55;
	localparam logic [7:0] ADDR_MAX = 8'h6B;
	localparam logic [7:0] OFS_CTRL_LO = 8'h00;
	localparam logic [7:0] OFS_CTRL_HI = 8'h01;
	localparam logic [7:0] OFS_FLAGS_LO = 8'h06;
	localparam logic [7:0] OFS_FLAGS_HI = 8'h07;
	localparam logic [7:0] OFS_CFG_LO = 8'h3A;
	localparam logic [7:0] OFS_CFG_HI = 8'h3B;
	// subcommand codes written to the control word
	localparam logic [15:0] CMD_RESET = 16'h0001;
	localparam logic [15:0] CMD_INSERT = 16'h0002;
	localparam logic [15:0] CMD_REMOVE = 16'h0003;
	localparam logic [15:0] CMD_ENTER_CFG = 16'h0004;
	localparam logic [15:0] CMD_EXIT_CFG = 16'h0005;
	localparam logic [15:0] CMD_SET_HIB = 16'h0006;
	localparam logic [15:0] CMD_CLR_HIB = 16'h0007;
	// working configuration word and its bits
	localparam logic [15:0] CFG_DEFAULT = 16'h89F8;
	localparam int CFG_PIN_DETECT = 13;
	localparam int CFG_PULLUP = 12;
	localparam int CFG_SLEEP = 5;
	localparam int CFG_FILL = 4;
	// clocks and times
	localparam int CLK_HZ = 40_000_000;
	localparam int LINK_HZ = 8_000_000;
	localparam int TICK_S = 1;
	localparam int TICK_CYC = CLK_HZ * TICK_S;
	localparam int BUS_TIMEOUT_S = 2;
	localparam int BUS_TO_CYC = LINK_HZ * BUS_TIMEOUT_S;
	localparam int STUCK_GRACE_CYC = 8;
	localparam int TERM_SPAN_S = 80;
	localparam int CFG_TIMEOUT_S = 240;
	localparam int CAL_CYC = 16;
	// electrical thresholds
	localparam int TAPER_MA = 75;
	localparam int SLEEP_MA = 10;
	localparam int TERM_DV_MV = 100;
	localparam int TERM_GAIN_UAH = 500;
	typedef enum logic [2:0] {M_INIT, M_OCV, M_NORMAL, M_CFG, M_CAL, M_SLEEP, M_HIB} gmhp_mode_t;
	typedef enum logic [2:0] {L_IDLE, L_RX, L_ACK, L_TX, L_TXACK} gmhp_link_t;
	typedef enum logic [1:0] {K_ADDR, K_CMD, K_DATA} gmhp_kind_t;
	typedef struct packed {
		logic [4:0] spare;
		logic bus_stuck;
		logic sleeping;
		logic hib_req;
		logic present;
		logic rest_voltage_taken_flag;
		logic term_detect;
		logic charging;
		logic impedance_learned_flag;
		logic capacity_learned;
		logic config_mode_flag;
		logic defaults_loaded_flag;
	} gmhp_flags_t;
	typedef struct packed {
		logic [7:0] ofs;
		logic [15:0] value;
	} gmhp_wr_t;
	typedef struct packed {
		gmhp_flags_t flags;
		logic [15:0] cfg;
		logic [7:0] mode;
	} gmhp_snap_t;
	typedef struct packed {
		logic scl;
		logic sda;
	} gmhp_bus_t;
endpackage : gmhp_pkg
`default_nettype wire

/* src/gmhp_sync2.sv */
// two flip-flop level synchroniser
`default_nettype none
module gmhp_sync2 #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// levels
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_ff;
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			meta_ff <= RST;
			q_o <= RST;
		end else begin
			meta_ff <= d_i;
			q_o <= meta_ff;
		end
	end
endmodule : gmhp_sync2
`default_nettype wire

/* src/gmhp_top.sv */
// gauge mode controller with its serial host port on the link clock
//
// Summary of operation
// - pin edges mark insertion and removal when enabled
// - subcommands mark insertion and removal otherwise
// - normal only after insertion and initialization
// - taper current, charge gain, voltage give termination
// - termination clears charging, optionally fills charge left
// - reset loads default configuration, enters initialization
// - reset or reset subcommand sets defaults flag
// - insertion starts rest voltage measurement, clears learning
// - halted initialization wakes briefly per host command
// - enter subcommand sets config flag, suspends gauging
// - exit subcommand resumes, clears defaults and config
// - config mode ends alone after 240 seconds
// - normal mode samples and refreshes every second
// - low current with sleep enabled: calibrate, sleep
// - sleep ends once the low current condition fails and the bus is not stuck
// - hibernate request plus rest reading or low voltage
// - hibernate ends on addressed traffic or pin removal only
// - target at fixed address with three transfer kinds
// - pointer advances on every acknowledged data byte
// - refuse high register addresses and read-only writes
// - bus low two seconds: release, sleep if stuck
// - weak presence pull-up only when configured
`default_nettype none
module gmhp_top #(
	parameter int TICK_CYC = gmhp_pkg::TICK_CYC,
	parameter int BUS_TO_CYC = gmhp_pkg::BUS_TO_CYC,
	parameter int TAPER_MA = gmhp_pkg::TAPER_MA,
	parameter int SLEEP_MA = gmhp_pkg::SLEEP_MA
) (
	// clocks and reset
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic link_clk_i,
	// battery presence
	input wire logic battery_presence_pin_i,
	output logic presence_pullup_enable_o,
	// host serial bus, open drain
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// measurements and estimator results
	input wire logic signed [15:0] mean_current_i,
	input wire logic [15:0] voltage_i,
	input wire logic [15:0] charge_voltage_i,
	input wire logic [15:0] charge_gain_i,
	input wire logic [15:0] hib_current_i,
	input wire logic [15:0] hib_voltage_i,
	input wire logic [15:0] charge_left_i,
	input wire logic [15:0] full_charge_amount_i,
	input wire logic charging_i,
	input wire logic ocv_done_i,
	input wire logic cap_learned_i,
	input wire logic imp_learned_i,
	// mode and status
	output gmhp_pkg::gmhp_mode_t mode_o,
	output gmhp_pkg::gmhp_flags_t flags_o,
	output logic [15:0] config_o,
	output logic [15:0] charge_left_o,
	output logic sample_o,
	output logic ocv_start_o,
	output logic cal_start_o,
	output logic awake_o
);
	// link domain reset
	logic lrst;
	gmhp_sync2 #(.W(1), .RST(1'b1)) u_lrst (.clk_i(link_clk_i), .srst_i(1'b0), .d_i(srst_i),
		.q_o(lrst));

	// link side: pins, edges and bus timeout
	gmhp_pkg::gmhp_bus_t pin_s;
	gmhp_pkg::gmhp_bus_t pin_p_ff;
	gmhp_sync2 #(.W(2), .RST(2'b11)) u_pin_sync (.clk_i(link_clk_i), .srst_i(lrst),
		.d_i({scl_i, sda_i}), .q_o(pin_s));
	wire scl_rise = pin_s.scl & ~pin_p_ff.scl;
	wire scl_fall = ~pin_s.scl & pin_p_ff.scl;
	wire start_c = pin_s.scl & pin_p_ff.scl & pin_p_ff.sda & ~pin_s.sda;
	wire stop_c = pin_s.scl & pin_p_ff.scl & ~pin_p_ff.sda & pin_s.sda;
	wire line_low = ~pin_s.scl | ~pin_s.sda;
	logic [24:0] to_cnt_ff;
	logic stuck_ff;
	wire bus_to = line_low && to_cnt_ff == 25'(BUS_TO_CYC - 1);
	wire stuck_set = line_low && to_cnt_ff == 25'(BUS_TO_CYC + gmhp_pkg::STUCK_GRACE_CYC);

	// link side: target engine state
	gmhp_pkg::gmhp_link_t lstate_ff, nxt_lstate;
	gmhp_pkg::gmhp_kind_t kind_ff, nxt_kind;
	logic [3:0] bit_ff, nxt_bit;
	logic [7:0] sh_ff, nxt_sh;
	logic [7:0] ptr_ff, nxt_ptr;
	logic [7:0] lo_ff;
	logic ack_ff, nxt_ack;
	logic rw_ff, nxt_rw;
	logic sda_oe_ff, nxt_oe;
	logic wr_ack;
	logic addr_hit;
	logic start_tg_ff;
	logic hit_tg_ff;
	logic drv_lvl_ff;
	gmhp_pkg::gmhp_snap_t snap_l;

	function automatic logic is_writable(input logic [7:0] ofs);
		is_writable = ofs == gmhp_pkg::OFS_CTRL_LO || ofs == gmhp_pkg::OFS_CTRL_HI ||
			ofs == gmhp_pkg::OFS_CFG_LO || ofs == gmhp_pkg::OFS_CFG_HI;
	endfunction : is_writable

	function automatic logic [7:0] rd_byte(input logic [7:0] ofs, input gmhp_pkg::gmhp_snap_t s);
		case (ofs)
			gmhp_pkg::OFS_CTRL_LO: rd_byte = s.mode;
			gmhp_pkg::OFS_FLAGS_LO: rd_byte = s.flags[7:0];
			gmhp_pkg::OFS_FLAGS_HI: rd_byte = s.flags[15:8];
			gmhp_pkg::OFS_CFG_LO: rd_byte = s.cfg[7:0];
			gmhp_pkg::OFS_CFG_HI: rd_byte = s.cfg[15:8];
			default: rd_byte = 8'h00;
		endcase
	endfunction : rd_byte

	wire [7:0] byte_in = {sh_ff[6:0], pin_s.sda};
	wire [7:0] tx_byte = rd_byte(ptr_ff, snap_l);
	wire [7:0] tx_next = rd_byte(nxt_ptr, snap_l);
	wire rx_ack = kind_ff == gmhp_pkg::K_ADDR ? byte_in[7:1] == gmhp_pkg::DEV_ADDR :
		kind_ff == gmhp_pkg::K_CMD ? byte_in <= gmhp_pkg::ADDR_MAX :
		is_writable(ptr_ff);
	wire wr_fire = wr_ack && (ptr_ff == gmhp_pkg::OFS_CTRL_HI || ptr_ff == gmhp_pkg::OFS_CFG_HI);

	always_comb begin
		nxt_lstate = lstate_ff;
		nxt_kind = kind_ff;
		nxt_bit = bit_ff;
		nxt_sh = sh_ff;
		nxt_ptr = ptr_ff;
		nxt_ack = ack_ff;
		nxt_rw = rw_ff;
		nxt_oe = sda_oe_ff;
		wr_ack = 1'b0;
		addr_hit = 1'b0;
		if (bus_to) begin
			nxt_lstate = gmhp_pkg::L_IDLE;
			nxt_oe = 1'b0;
		end else if (start_c) begin
			nxt_lstate = gmhp_pkg::L_RX;
			nxt_kind = gmhp_pkg::K_ADDR;
			nxt_bit = 4'd0;
			nxt_oe = 1'b0;
		end else if (stop_c) begin
			nxt_lstate = gmhp_pkg::L_IDLE;
			nxt_oe = 1'b0;
		end else begin
			unique case (lstate_ff)
				gmhp_pkg::L_IDLE: begin
				end
				gmhp_pkg::L_RX: begin
					if (scl_rise) begin
						nxt_sh = byte_in;
						nxt_bit = bit_ff + 4'd1;
						if (bit_ff == 4'd7) begin
							nxt_ack = rx_ack;
						end
					end else if (scl_fall && bit_ff == 4'd8) begin
						nxt_lstate = gmhp_pkg::L_ACK;
						nxt_oe = ack_ff;
						nxt_bit = 4'd0;
						if (kind_ff == gmhp_pkg::K_ADDR) begin
							nxt_rw = sh_ff[0];
							addr_hit = ack_ff;
						end else if (kind_ff == gmhp_pkg::K_CMD && ack_ff) begin
							nxt_ptr = sh_ff;
						end else if (ack_ff) begin
							wr_ack = 1'b1;
							nxt_ptr = ptr_ff + 8'd1;
						end
					end
				end
				gmhp_pkg::L_ACK: begin
					if (scl_fall) begin
						nxt_oe = 1'b0;
						if (!ack_ff) begin
							nxt_lstate = gmhp_pkg::L_IDLE;
						end else if (kind_ff == gmhp_pkg::K_ADDR && rw_ff) begin
							nxt_lstate = gmhp_pkg::L_TX;
							nxt_sh = tx_byte;
							nxt_oe = ~tx_byte[7];
						end else begin
							nxt_lstate = gmhp_pkg::L_RX;
							nxt_kind = kind_ff == gmhp_pkg::K_ADDR ? gmhp_pkg::K_CMD : gmhp_pkg::K_DATA;
						end
					end
				end
				gmhp_pkg::L_TX: begin
					if (scl_rise) begin
						nxt_bit = bit_ff + 4'd1;
					end else if (scl_fall && bit_ff == 4'd8) begin
						nxt_lstate = gmhp_pkg::L_TXACK;
						nxt_oe = 1'b0;
						nxt_bit = 4'd0;
					end else if (scl_fall) begin
						nxt_sh = {sh_ff[6:0], 1'b0};
						nxt_oe = ~sh_ff[6];
					end
				end
				gmhp_pkg::L_TXACK: begin
					if (scl_rise) begin
						nxt_ack = ~pin_s.sda;
						if (!pin_s.sda) begin
							nxt_ptr = ptr_ff + 8'd1;
						end
					end else if (scl_fall && ack_ff) begin
						nxt_lstate = gmhp_pkg::L_TX;
						nxt_sh = tx_next;
						nxt_oe = ~tx_next[7];
					end else if (scl_fall) begin
						nxt_lstate = gmhp_pkg::L_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge link_clk_i) begin
		if (lrst) begin
			lstate_ff <= gmhp_pkg::L_IDLE;
			kind_ff <= gmhp_pkg::K_ADDR;
			bit_ff <= 4'd0;
			sh_ff <= 8'h00;
			ptr_ff <= 8'h00;
			ack_ff <= 1'b0;
			rw_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
		end else begin
			lstate_ff <= nxt_lstate;
			kind_ff <= nxt_kind;
			bit_ff <= nxt_bit;
			sh_ff <= nxt_sh;
			ptr_ff <= nxt_ptr;
			ack_ff <= nxt_ack;
			rw_ff <= nxt_rw;
			sda_oe_ff <= nxt_oe;
		end
	end

	always_ff @(posedge link_clk_i) begin
		if (lrst) begin
			pin_p_ff <= 2'b11;
			to_cnt_ff <= 25'd0;
			stuck_ff <= 1'b0;
			lo_ff <= 8'h00;
			start_tg_ff <= 1'b0;
			hit_tg_ff <= 1'b0;
			drv_lvl_ff <= 1'b0;
		end else begin
			pin_p_ff <= pin_s;
			// counter parks at the grace point so a stuck bus is reported once
			to_cnt_ff <= !line_low ? 25'd0 : stuck_set ? to_cnt_ff : to_cnt_ff + 25'd1;
			stuck_ff <= line_low && (stuck_ff || stuck_set);
			lo_ff <= wr_ack ? sh_ff : lo_ff;
			start_tg_ff <= start_tg_ff ^ start_c;
			hit_tg_ff <= hit_tg_ff ^ addr_hit;
			drv_lvl_ff <= 1'b0;
		end
	end
	assign sda_oe_o = sda_oe_ff;
	assign sda_o = drv_lvl_ff;
	assign scl_o = drv_lvl_ff;
	assign scl_oe_o = drv_lvl_ff;

	// crossings between the two domains
	gmhp_pkg::gmhp_wr_t wr_word;
	logic wr_valid;
	gmhp_pkg::gmhp_snap_t snap_c;
	gmhp_pkg::gmhp_snap_t sent_ff;
	logic snap_busy;
	logic [2:0] ev_s;
	logic [1:0] ev_p_ff;
	gmhp_xfer #(.W(24)) u_wr_xfer (.s_clk_i(link_clk_i), .s_rst_i(lrst), .s_valid_i(wr_fire),
		.s_data_i({ptr_ff, sh_ff, lo_ff}), .s_busy_o(), .d_clk_i(clk_i), .d_rst_i(srst_i),
		.d_valid_o(wr_valid), .d_data_o(wr_word));
	gmhp_xfer #(.W(40)) u_snap_xfer (.s_clk_i(clk_i), .s_rst_i(srst_i),
		.s_valid_i(snap_c != sent_ff), .s_data_i(snap_c), .s_busy_o(snap_busy),
		.d_clk_i(link_clk_i), .d_rst_i(lrst), .d_valid_o(), .d_data_o(snap_l));
	gmhp_sync2 #(.W(3)) u_ev_sync (.clk_i(clk_i), .srst_i(srst_i),
		.d_i({stuck_ff, hit_tg_ff, start_tg_ff}), .q_o(ev_s));
	wire start_evt = ev_s[0] ^ ev_p_ff[0];
	wire hit_evt = ev_s[1] ^ ev_p_ff[1];
	wire bus_stuck = ev_s[2];

	// core side: presence pin
	logic pin_sync;
	logic pin_p_c_ff;
	gmhp_sync2 #(.W(1), .RST(1'b1)) u_bin_sync (.clk_i(clk_i), .srst_i(srst_i),
		.d_i(battery_presence_pin_i), .q_o(pin_sync));

	// core side: decode
	gmhp_pkg::gmhp_mode_t mode_ff, nxt_mode;
	gmhp_pkg::gmhp_flags_t flags_ff;
	logic [15:0] cfg_ff;
	logic [25:0] sec_cnt_ff;
	logic [7:0] cfg_tmr_ff;
	logic [6:0] term_cnt_ff;
	logic [23:0] term_acc_ff;
	logic term_latch_ff;
	logic [4:0] cal_cnt_ff;
	wire tick = sec_cnt_ff == 26'(TICK_CYC - 1);
	wire cmd_evt = wr_valid && wr_word.ofs == gmhp_pkg::OFS_CTRL_HI;
	wire [15:0] sub = wr_word.value;
	wire pin_mode = cfg_ff[gmhp_pkg::CFG_PIN_DETECT];
	wire ins_evt = pin_mode ? pin_p_c_ff & ~pin_sync :
		cmd_evt && sub == gmhp_pkg::CMD_INSERT;
	wire rem_evt = pin_mode ? ~pin_p_c_ff & pin_sync :
		cmd_evt && sub == gmhp_pkg::CMD_REMOVE;
	wire reset_cmd = cmd_evt && sub == gmhp_pkg::CMD_RESET;
	wire enter_cmd = cmd_evt && sub == gmhp_pkg::CMD_ENTER_CFG;
	wire exit_cmd = cmd_evt && sub == gmhp_pkg::CMD_EXIT_CFG;
	wire cfg_end = mode_ff == gmhp_pkg::M_CFG &&
		(exit_cmd || (tick && cfg_tmr_ff == 8'(gmhp_pkg::CFG_TIMEOUT_S - 1)));
	wire sleep_ok = cfg_ff[gmhp_pkg::CFG_SLEEP] && mean_current_i < SLEEP_MA;
	wire [15:0] cur_mag = mean_current_i[15] ? 16'(-mean_current_i) : mean_current_i;
	wire hib_go = flags_ff.hib_req && ((flags_ff.rest_voltage_taken_flag && cur_mag < hib_current_i)
		|| voltage_i < hib_voltage_i);
	wire term_cond = mean_current_i < TAPER_MA &&
		voltage_i > charge_voltage_i - 16'(gmhp_pkg::TERM_DV_MV);
	wire [23:0] term_sum = term_acc_ff + {8'h00, charge_gain_i};
	wire term_fire = tick && mode_ff == gmhp_pkg::M_NORMAL && term_cond && !term_latch_ff &&
		term_cnt_ff == 7'(gmhp_pkg::TERM_SPAN_S - 1) && term_sum > 24'(gmhp_pkg::TERM_GAIN_UAH);
	wire halted = mode_ff == gmhp_pkg::M_INIT || mode_ff == gmhp_pkg::M_SLEEP ||
		mode_ff == gmhp_pkg::M_HIB;

	always_comb begin
		nxt_mode = mode_ff;
		unique case (mode_ff)
			gmhp_pkg::M_INIT: if (flags_ff.present) nxt_mode = gmhp_pkg::M_OCV;
			gmhp_pkg::M_OCV: if (ocv_done_i) nxt_mode = gmhp_pkg::M_NORMAL;
			gmhp_pkg::M_NORMAL: begin
				if (tick && hib_go) begin
					nxt_mode = gmhp_pkg::M_HIB;
				end else if (tick && (bus_stuck || sleep_ok)) begin
					nxt_mode = gmhp_pkg::M_CAL;
				end
			end
			gmhp_pkg::M_CAL: begin
				if (cal_cnt_ff == 5'(gmhp_pkg::CAL_CYC - 1)) nxt_mode = gmhp_pkg::M_SLEEP;
			end
			gmhp_pkg::M_SLEEP: if (!sleep_ok && !bus_stuck) nxt_mode = gmhp_pkg::M_NORMAL;
			gmhp_pkg::M_HIB: if (hit_evt) nxt_mode = gmhp_pkg::M_NORMAL;
			gmhp_pkg::M_CFG: begin
				if (cfg_end) begin
					nxt_mode = flags_ff.rest_voltage_taken_flag ? gmhp_pkg::M_NORMAL : gmhp_pkg::M_INIT;
				end
			end
		endcase
		if (enter_cmd && mode_ff != gmhp_pkg::M_CFG) begin
			nxt_mode = gmhp_pkg::M_CFG;
		end else if (rem_evt && mode_ff != gmhp_pkg::M_CFG) begin
			nxt_mode = gmhp_pkg::M_INIT;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			mode_ff <= gmhp_pkg::M_INIT;
			cfg_ff <= gmhp_pkg::CFG_DEFAULT;
			sec_cnt_ff <= 26'd0;
			cfg_tmr_ff <= 8'd0;
			cal_cnt_ff <= 5'd0;
			pin_p_c_ff <= 1'b1;
			ev_p_ff <= 2'b00;
			sent_ff <= '0;
		end else begin
			mode_ff <= nxt_mode;
			if (reset_cmd) begin
				cfg_ff <= gmhp_pkg::CFG_DEFAULT;
			end else if (wr_valid && wr_word.ofs == gmhp_pkg::OFS_CFG_HI && mode_ff == gmhp_pkg::M_CFG) begin
				cfg_ff <= wr_word.value;
			end
			sec_cnt_ff <= tick ? 26'd0 : sec_cnt_ff + 26'd1;
			cfg_tmr_ff <= mode_ff != gmhp_pkg::M_CFG ? 8'd0 : cfg_tmr_ff + {7'd0, tick};
			cal_cnt_ff <= mode_ff == gmhp_pkg::M_CAL ? cal_cnt_ff + 5'd1 : 5'd0;
			pin_p_c_ff <= pin_sync;
			ev_p_ff <= ev_s[1:0];
			// snapshot is resent whenever it differs from what the link last got
			sent_ff <= (snap_c != sent_ff && !snap_busy) ? snap_c : sent_ff;
		end
	end

	// charge termination window
	always_ff @(posedge clk_i) begin
		if (srst_i || !term_cond) begin
			term_cnt_ff <= 7'd0;
			term_acc_ff <= 24'd0;
			term_latch_ff <= 1'b0;
		end else if (tick && mode_ff == gmhp_pkg::M_NORMAL) begin
			if (term_cnt_ff != 7'(gmhp_pkg::TERM_SPAN_S - 1)) begin
				term_cnt_ff <= term_cnt_ff + 7'd1;
				term_acc_ff <= term_sum;
			end
			term_latch_ff <= term_latch_ff | term_fire;
		end
	end

	// flags and status
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			flags_ff <= '0;
			flags_ff.defaults_loaded_flag <= 1'b1;
		end else begin
			if (reset_cmd) begin
				flags_ff.defaults_loaded_flag <= 1'b1;
			end else if (cfg_end) begin
				flags_ff.defaults_loaded_flag <= 1'b0;
			end
			flags_ff.config_mode_flag <= nxt_mode == gmhp_pkg::M_CFG;
			flags_ff.capacity_learned <= cap_learned_i | (flags_ff.capacity_learned & ~ins_evt);
			flags_ff.impedance_learned_flag <= imp_learned_i |
				(flags_ff.impedance_learned_flag & ~ins_evt);
			if (term_fire) begin
				flags_ff.charging <= 1'b0;
			end else if (tick) begin
				flags_ff.charging <= charging_i & ~term_latch_ff;
			end
			flags_ff.term_detect <= term_fire | (flags_ff.term_detect & term_cond);
			if (mode_ff == gmhp_pkg::M_OCV && ocv_done_i) begin
				flags_ff.rest_voltage_taken_flag <= 1'b1;
			end else if (ins_evt || rem_evt) begin
				flags_ff.rest_voltage_taken_flag <= 1'b0;
			end
			flags_ff.present <= ins_evt | (flags_ff.present & ~rem_evt);
			if (cmd_evt && sub == gmhp_pkg::CMD_SET_HIB) begin
				flags_ff.hib_req <= 1'b1;
			end else if (cmd_evt && sub == gmhp_pkg::CMD_CLR_HIB) begin
				flags_ff.hib_req <= 1'b0;
			end
			flags_ff.sleeping <= nxt_mode == gmhp_pkg::M_SLEEP;
			flags_ff.bus_stuck <= bus_stuck;
		end
	end

	// outputs toward the rest of the gauge
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			charge_left_o <= 16'h0000;
			sample_o <= 1'b0;
			ocv_start_o <= 1'b0;
			cal_start_o <= 1'b0;
			awake_o <= 1'b0;
			presence_pullup_enable_o <= 1'b0;
		end else begin
			if (term_fire && cfg_ff[gmhp_pkg::CFG_FILL]) begin
				charge_left_o <= full_charge_amount_i;
			end else if (tick && mode_ff == gmhp_pkg::M_NORMAL) begin
				charge_left_o <= charge_left_i;
			end
			sample_o <= tick && (mode_ff == gmhp_pkg::M_NORMAL || mode_ff == gmhp_pkg::M_SLEEP);
			ocv_start_o <= mode_ff == gmhp_pkg::M_INIT && nxt_mode == gmhp_pkg::M_OCV;
			cal_start_o <= mode_ff == gmhp_pkg::M_NORMAL && nxt_mode == gmhp_pkg::M_CAL;
			// halted modes wake for one cycle per command or start seen, hibernate per start only
			awake_o <= !halted || (mode_ff == gmhp_pkg::M_HIB ? start_evt : wr_valid | start_evt);
			presence_pullup_enable_o <= cfg_ff[gmhp_pkg::CFG_PULLUP];
		end
	end
	assign snap_c = {flags_ff, cfg_ff, {5'd0, mode_ff}};
	assign mode_o = mode_ff;
	assign flags_o = flags_ff;
	assign config_o = cfg_ff;
endmodule : gmhp_top
`default_nettype wire

/* src/gmhp_xfer.sv */
// toggle handshake that carries one word between two clock domains
`default_nettype none
module gmhp_xfer #(
	parameter int W = 8
) (
	// source side
	input wire logic s_clk_i,
	input wire logic s_rst_i,
	input wire logic s_valid_i,
	input wire logic [W-1:0] s_data_i,
	output logic s_busy_o,
	// destination side
	input wire logic d_clk_i,
	input wire logic d_rst_i,
	output logic d_valid_o,
	output logic [W-1:0] d_data_o
);
	logic req_ff;
	logic ack_ff;
	logic [W-1:0] hold_ff;
	logic ack_s;
	logic req_s;
	gmhp_sync2 #(.W(1)) u_ack_sync (.clk_i(s_clk_i), .srst_i(s_rst_i), .d_i(ack_ff), .q_o(ack_s));
	gmhp_sync2 #(.W(1)) u_req_sync (.clk_i(d_clk_i), .srst_i(d_rst_i), .d_i(req_ff), .q_o(req_s));
	// a word offered while busy is dropped, the source must pace itself
	assign s_busy_o = req_ff ^ ack_s;
	always_ff @(posedge s_clk_i) begin
		if (s_rst_i) begin
			req_ff <= 1'b0;
			hold_ff <= '0;
		end else if (s_valid_i && !s_busy_o) begin
			req_ff <= ~req_ff;
			hold_ff <= s_data_i;
		end
	end
	// hold_ff is stable for two destination edges before the request is seen
	always_ff @(posedge d_clk_i) begin
		if (d_rst_i) begin
			ack_ff <= 1'b0;
			d_valid_o <= 1'b0;
			d_data_o <= '0;
		end else begin
			d_valid_o <= req_s ^ ack_ff;
			if (req_s ^ ack_ff) begin
				ack_ff <= req_s;
				d_data_o <= hold_ff;
			end
		end
	end
endmodule : gmhp_xfer
`default_nettype wire

/* verification/gauge_mode_and_host_port_tb_top.sv */
// self-checking bench for the gauge mode controller
`default_nettype none
module gauge_mode_and_host_port_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic link_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic pin = 1'b1;
	logic ocv = 1'b0;
	logic signed [15:0] cur = 16'sd100;
	logic [15:0] an [7] = '{16'h0ED8, 16'h1068, 16'h0000, 16'h0014, 16'h0BB8, 16'h0000, 16'h0400};
	logic [2:0] bits = 3'h0;
	logic h_scl, h_sda, scl_oe, scl_o, sda_oe, sda_o, pull;
	int err_count = 0;
	int n_checks = 0;
	gmhp_pkg::gmhp_mode_t mode;
	gmhp_pkg::gmhp_flags_t flags;
	logic [15:0] cfg;
	wire logic scl = !(h_scl || (scl_oe && !scl_o));
	wire logic sda = !(h_sda || (sda_oe && !sda_o));
	always #12.5 clk_i = !clk_i;
	initial begin
		#3.1;
		forever #62.5 link_clk_i = !link_clk_i;
	end
	gmhp_host host (.lclk_i(link_clk_i), .sda_i(sda), .scl_oe_o(h_scl), .sda_oe_o(h_sda));
	gmhp_top #(.TICK_CYC(200), .BUS_TO_CYC(1000)) DUT (.clk_i, .srst_i, .link_clk_i,
		.battery_presence_pin_i(pin), .presence_pullup_enable_o(pull), .scl_i(scl), .scl_o,
		.scl_oe_o(scl_oe), .sda_i(sda), .sda_o, .sda_oe_o(sda_oe), .mean_current_i(cur),
		.voltage_i(an[0]), .charge_voltage_i(an[1]), .charge_gain_i(an[2]), .hib_current_i(an[3]),
		.hib_voltage_i(an[4]), .charge_left_i(an[5]), .full_charge_amount_i(an[6]),
		.charging_i(bits[0]), .ocv_done_i(ocv), .cap_learned_i(bits[1]), .imp_learned_i(bits[2]),
		.mode_o(mode), .flags_o(flags), .config_o(cfg), .charge_left_o(), .sample_o(),
		.ocv_start_o(), .cal_start_o(), .awake_o());
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic frame(input logic [31:0] d, output logic [3:0] a);
		logic [8:0] r;
		host.seq(1'b0, 1'b1, r[0]);
		for (int i = 3; i >= 0; i--) begin
			host.xbyte({d[i*8+:8], 1'b1}, r);
			a[i] = !r[0];
		end
		host.seq(1'b1, 1'b0, r[0]);
	endtask : frame
	task automatic sub(input logic [15:0] c);
		logic [3:0] a;
		frame({16'hAA00, c[7:0], c[15:8]}, a);
		chk(16'(a), 16'h000F);
	endtask : sub
	task automatic rd(input logic [7:0] ofs, output logic [15:0] v);
		logic [8:0] r;
		host.seq(1'b0, 1'b1, r[0]);
		host.xbyte(9'h155, r);
		host.xbyte({ofs, 1'b1}, r);
		host.seq(1'b0, 1'b1, r[0]);
		host.xbyte(9'h157, r);
		host.xbyte(9'h1FE, r);
		v[7:0] = r[8:1];
		host.xbyte(9'h1FF, r);
		v[15:8] = r[8:1];
		host.seq(1'b1, 1'b0, r[0]);
	endtask : rd
	task automatic wmode(input gmhp_pkg::gmhp_mode_t m, input int n);
		for (int i = 0; i < n && mode !== m; i++) begin
			@(posedge clk_i);
			#1;
		end
		chk(16'(mode), 16'(m));
	endtask : wmode
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out
	initial begin
		#2ms;
		err_count++;
		close_out();
	end
	initial begin
		logic [3:0] a;
		logic [15:0] v;
		logic [15:0] nc;
		nc = gmhp_pkg::CFG_DEFAULT | 16'h3000;
		// link side needs several of its own edges inside reset
		repeat (16) @(posedge clk_i);
		srst_i <= 1'b0;
		wmode(gmhp_pkg::M_INIT, 1);
		chk(cfg, gmhp_pkg::CFG_DEFAULT);
		chk(16'(flags.defaults_loaded_flag), 16'h0001);
		repeat (40) @(posedge clk_i);
		frame(32'hA800_0200, a);
		chk(16'(a), 16'h0000);
		wmode(gmhp_pkg::M_INIT, 20);
		$display("reset and address done");
		sub(gmhp_pkg::CMD_INSERT);
		wmode(gmhp_pkg::M_OCV, 20);
		@(posedge clk_i) ocv <= 1'b1;
		wmode(gmhp_pkg::M_NORMAL, 10);
		@(posedge clk_i) ocv <= 1'b0;
		sub(gmhp_pkg::CMD_ENTER_CFG);
		wmode(gmhp_pkg::M_CFG, 20);
		frame({16'hAA3A, nc[7:0], nc[15:8]}, a);
		rd(8'h3A, v);
		chk(v, nc);
		sub(gmhp_pkg::CMD_EXIT_CFG);
		wmode(gmhp_pkg::M_NORMAL, 20);
		chk(16'({flags.defaults_loaded_flag, flags.config_mode_flag}), 16'h0000);
		chk(16'(pull), 16'h0001);
		$display("config done");
		@(posedge clk_i) cur <= 16'sd5;
		wmode(gmhp_pkg::M_SLEEP, 300);
		@(posedge clk_i) cur <= 16'sd50;
		wmode(gmhp_pkg::M_NORMAL, 5);
		sub(gmhp_pkg::CMD_SET_HIB);
		@(posedge clk_i) cur <= 16'sd5;
		wmode(gmhp_pkg::M_HIB, 300);
		frame(32'hA800_0000, a);
		wmode(gmhp_pkg::M_HIB, 1);
		@(posedge clk_i) cur <= 16'sd50;
		sub(gmhp_pkg::CMD_CLR_HIB);
		wmode(gmhp_pkg::M_NORMAL, 20);
		$display("power modes done");
		@(posedge clk_i) pin <= 1'b0;
		repeat (20) @(posedge clk_i);
		@(posedge clk_i) pin <= 1'b1;
		wmode(gmhp_pkg::M_INIT, 20);
		@(posedge clk_i) pin <= 1'b0;
		wmode(gmhp_pkg::M_OCV, 20);
		frame(32'hAA6C_0000, a);
		chk(16'(a), 16'h0008);
		frame(32'hAA06_0000, a);
		chk(16'(a), 16'h000C);
		$display("pin and refusals done");
		close_out();
	end
endmodule : gauge_mode_and_host_port_tb_top
`default_nettype wire

/* verification/gmhp_host.sv */
// host controller model on the serial bus, open drain pulls only
`default_nettype none
module gmhp_host (
	// pacing clock
	input wire logic lclk_i,
	// bus
	input wire logic sda_i,
	output logic scl_oe_o,
	output logic sda_oe_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl_oe_o = 1'b0;
		sda_oe_o = 1'b0;
	end
	task automatic pin2(input logic c, input logic d);
		scl_oe_o <= c;
		sda_oe_o <= d;
		repeat (4) @(posedge lclk_i);
	endtask : pin2
	// data moves only while scl is low; start and stop move it with scl high
	task automatic seq(input logic a, input logic b, output logic r);
		pin2(1'b1, sda_oe_o);
		pin2(1'b1, a);
		pin2(1'b0, a);
		r = sda_i;
		pin2(1'b0, b);
	endtask : seq
	// d holds eight bits then the ack bit; a one releases the line
	task automatic xbyte(input logic [8:0] d, output logic [8:0] r);
		for (int i = 8; i >= 0; i--) seq(!d[i], !d[i], r[i]);
	endtask : xbyte
endmodule : gmhp_host
`default_nettype wire

/* verification/gmhp_props.sv */
// port checks for the gauge mode controller
`default_nettype none
module gmhp_props #(
	parameter int SLEEP_MA = gmhp_pkg::SLEEP_MA
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// watched ports
	input wire logic signed [15:0] mean_current_i,
	input wire gmhp_pkg::gmhp_mode_t mode_o,
	input wire gmhp_pkg::gmhp_flags_t flags_o,
	input wire logic [15:0] config_o,
	input wire logic presence_pullup_enable_o,
	input wire logic sample_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	wire logic in_cfg = mode_o == gmhp_pkg::M_CFG;
	wire logic in_slp = mode_o == gmhp_pkg::M_SLEEP;
	reset_state_a:
	assert property ($fell(srst_i) |-> mode_o == gmhp_pkg::M_INIT && config_o ==
		gmhp_pkg::CFG_DEFAULT && flags_o.defaults_loaded_flag) else $error("reset state");
	pullup_follow_a:
	assert property (presence_pullup_enable_o == $past(config_o[gmhp_pkg::CFG_PULLUP]))
		else $error("pullup");
	init_hold_a:
	assert property ($past(mode_o) == gmhp_pkg::M_INIT |-> mode_o != gmhp_pkg::M_NORMAL)
		else $error("init skipped");
	sleep_entry_a:
	assert property ($rose(in_slp) |-> $past(mode_o) == gmhp_pkg::M_CAL) else $error("no cal");
	sleep_exit_a:
	assert property (in_slp && mean_current_i > SLEEP_MA && !flags_o.bus_stuck |-> ##[1:3]
		!in_slp) else $error("sleep kept");
	cfg_enter_a:
	assert property ($rose(in_cfg) |-> ##[0:2] flags_o.config_mode_flag) else $error("cfg flag");
	cfg_exit_a:
	assert property ($fell(in_cfg) |-> ##[0:2] !flags_o.config_mode_flag &&
		!flags_o.defaults_loaded_flag) else $error("cfg exit flags");
	hib_req_a:
	assert property ($rose(mode_o == gmhp_pkg::M_HIB) |-> $past(flags_o.hib_req))
		else $error("hib unrequested");
	sample_mode_a:
	assert property (sample_o |-> $past(mode_o) inside {gmhp_pkg::M_NORMAL, gmhp_pkg::M_SLEEP})
		else $error("stray sample");
	cover property (in_slp);
	cover property (mode_o == gmhp_pkg::M_HIB);
	cover property ($fell(in_cfg));
endmodule : gmhp_props
bind gmhp_top gmhp_props #(.SLEEP_MA(SLEEP_MA)) u_props (.clk_i, .srst_i, .mean_current_i,
	.mode_o, .flags_o, .config_o, .presence_pullup_enable_o, .sample_o);
`default_nettype wire
